// [flash_prog_defines.vh]
// constants for the flash programming mode entry block
`ifndef FLASH_PROG_DEFINES_VH
`define FLASH_PROG_DEFINES_VH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define SYS_CLK_HZ 50000000
`define INIT_WINDOW_MS 100
`define GUARD_BITS 4'hA

// ----------------------------------------------------------------------
// serial rates and bit periods in sys_clk cycles
// ----------------------------------------------------------------------
`define BAUD_115K 115200
`define BAUD_250K 250000
`define BAUD_500K 500000
`define BAUD_1M 1000000
`define SEL_115K 2'h0
`define SEL_250K 2'h1
`define SEL_500K 2'h2
`define SEL_1M 2'h3
// midpoints between neighbouring bit periods, used by the rate detector
`define THR_1M_500K 12'h04B
`define THR_500K_250K 12'h096
`define THR_250K_115K 12'h13D

// ----------------------------------------------------------------------
// option byte flash operating mode encoding
// ----------------------------------------------------------------------
`define OPM_BLANK 2'h0
`define OPM_HIGH_SPEED 2'h1
`define OPM_LOW_SPEED 2'h2
`define OPM_LOW_VOLTAGE 2'h3

// ----------------------------------------------------------------------
// operating frequency ceilings in MHz
// ----------------------------------------------------------------------
`define FMAX_FULL_2V7 6'h20
`define FMAX_FULL_2V4 6'h10
`define FMAX_LOW_SPEED 6'h08
`define FMAX_LOW_VOLT 6'h04

`endif

// [prog_tx_fifo.v]
// flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module prog_tx_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire sys_clk_i,
  input wire reset_n_i,
  // filling side
  input wire [WIDTH-1:0] in_data_i,
  input wire in_valid_i,
  output wire in_ready_o,
  // draining side
  output wire [WIDTH-1:0] out_data_o,
  output wire out_valid_o,
  input wire out_ready_i
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;

  assign in_ready_o = (count_r != DEPTH[AW:0]);
  assign out_valid_o = (count_r != {(AW+1){1'b0}});
  assign out_data_o = mem_r[rd_ptr_r];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always @(posedge sys_clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                    wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                    rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule // prog_tx_fifo

// [prog_baud_detect.v]
// rate detector: measures one low bit on the chosen line
`timescale 1ns/1ps
`include "flash_prog_defines.vh"
module prog_baud_detect (
  // clock and reset
  input wire sys_clk_i,
  input wire reset_n_i,
  // measurement
  input wire arm_i,
  input wire line_i,
  output reg done_o,
  output reg [1:0] sel_o
);
  reg busy_r;
  reg [11:0] width_r;

  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      busy_r <= 1'b0;
      width_r <= 12'h000;
      done_o <= 1'b0;
      sel_o <= `SEL_115K;
    end else begin
      done_o <= 1'b0;
      if (arm_i && !busy_r) begin
        busy_r <= 1'b1;
        width_r <= 12'h001;
      end else if (busy_r) begin
        if (line_i) begin
          // nearest of the four rates; saturated width falls to slowest
          busy_r <= 1'b0;
          done_o <= 1'b1;
          if (width_r < `THR_1M_500K) begin
            sel_o <= `SEL_1M;
          end else if (width_r < `THR_500K_250K) begin
            sel_o <= `SEL_500K;
          end else if (width_r < `THR_250K_115K) begin
            sel_o <= `SEL_250K;
          end else begin
            sel_o <= `SEL_115K;
          end
        end else if (width_r != 12'hFFF) begin
          width_r <= width_r + 12'h001;
        end
      end
    end
  end
endmodule // prog_baud_detect

// [flash_prog_mode_entry.v]
// boot mode strap, programming entry handshake and serial link
//
// Behaviour
// - strap high normal, low programming at release
// - internal resets finish before external release
// - entry completes after baud rate detection
// - mode fixed at release; programmer traffic does not switch it
// - unused pins keep their reset state
// - programming runs from internal fast oscillator
// - sub-mode from supply and option byte
// - high speed option: full at 2.4 V up
// - low speed option gives wide voltage
// - low voltage option gives wide voltage
// - blank option: full at 2.4 V up
// - both sub-modes allow all flash operations
// - one-line or two-wire uart, four rates
// - two-wire lines crossed with host lines
`timescale 1ns/1ps
`include "flash_prog_defines.vh"
module flash_prog_mode_entry #(
  parameter INIT_WINDOW_CYC = `SYS_CLK_HZ / 1000 * `INIT_WINDOW_MS,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  // clock and reset
  input wire sys_clk_i,
  input wire reset_n_i,
  // internal reset status
  input wire por_done_i,
  input wire brownout_done_i,
  // mode strap / one-line serial pin
  input wire mode_strap_i,
  output wire mode_strap_o,
  output wire mode_strap_oe_o,
  // two-wire serial pins
  input wire prog_uart_rx_i,
  output wire prog_uart_tx_o,
  // supply and option byte
  input wire [1:0] opt_op_mode_i,
  input wire vdd_ge_2v7_i,
  input wire vdd_ge_2v4_i,
  // mode status
  output wire normal_mode_o,
  output wire prog_mode_o,
  output wire entry_done_o,
  output wire init_timeout_o,
  output wire full_speed_o,
  output wire wide_voltage_o,
  output wire [5:0] freq_limit_mhz_o,
  output wire one_line_o,
  output wire [1:0] baud_sel_o,
  output wire fast_osc_sel_o,
  output wire port_hold_o,
  output wire flash_ops_en_o,
  // received bytes
  output reg [7:0] rx_data_o,
  output reg rx_valid_o,
  // bytes to send
  input wire [7:0] tx_data_i,
  input wire tx_valid_i,
  output wire tx_ready_o
);
  // ----------------------------------------------------------------------
  // states
  // ----------------------------------------------------------------------
  localparam ST_INIT = 3'h0;
  localparam ST_NORMAL = 3'h1;
  localparam ST_HOLD = 3'h2;
  localparam ST_SYNC = 3'h3;
  localparam ST_MEASURE = 3'h4;
  localparam ST_PROG = 3'h5;
  localparam ST_FAIL = 3'h6;
  localparam [31:0] WIN_LAST = INIT_WINDOW_CYC - 1;

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  function [15:0] bit_cycles;
    input [1:0] sel;
    reg [31:0] cyc;
    begin
      case (sel)
        `SEL_1M: cyc = `SYS_CLK_HZ / `BAUD_1M;
        `SEL_500K: cyc = `SYS_CLK_HZ / `BAUD_500K;
        `SEL_250K: cyc = `SYS_CLK_HZ / `BAUD_250K;
        default: cyc = `SYS_CLK_HZ / `BAUD_115K;
      endcase
      bit_cycles = cyc[15:0];
    end
  endfunction

  // 1 = full speed, 0 = wide voltage
  function sub_mode_full;
    input [1:0] opm;
    input ge_2v4;
    begin
      case (opm)
        `OPM_HIGH_SPEED: sub_mode_full = ge_2v4;
        `OPM_LOW_SPEED: sub_mode_full = 1'b0;
        `OPM_LOW_VOLTAGE: sub_mode_full = 1'b0;
        default: sub_mode_full = ge_2v4;
      endcase
    end
  endfunction

  function [5:0] freq_limit;
    input [1:0] opm;
    input ge_2v7;
    begin
      case (opm)
        `OPM_LOW_SPEED: freq_limit = `FMAX_LOW_SPEED;
        `OPM_LOW_VOLTAGE: freq_limit = `FMAX_LOW_VOLT;
        default: freq_limit = ge_2v7 ? `FMAX_FULL_2V7 : `FMAX_FULL_2V4;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // entry state machine
  // ----------------------------------------------------------------------
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [22:0] win_cnt_r;
  reg one_line_r;
  reg [1:0] baud_sel_r;
  reg full_speed_r;
  reg [5:0] freq_lim_r;
  reg strap_q_r;
  reg rx_pin_q_r;
  wire strap_fall;
  wire rx_pin_fall;
  wire baud_done;
  wire [1:0] baud_sel_det;
  wire meas_line;
  wire arm;
  wire win_expired;

  assign strap_fall = strap_q_r & ~mode_strap_i;
  assign rx_pin_fall = rx_pin_q_r & ~prog_uart_rx_i;
  assign win_expired = ({9'h000, win_cnt_r} == WIN_LAST);
  assign meas_line = one_line_r ? mode_strap_i : prog_uart_rx_i;
  assign arm = (state_r == ST_SYNC) && (strap_fall || rx_pin_fall);

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_INIT: begin
        // sample strap only once both internal resets are over
        if (por_done_i && brownout_done_i) begin
          state_nxt = mode_strap_i ? ST_NORMAL : ST_HOLD;
        end
      end
      ST_NORMAL: state_nxt = ST_NORMAL;
      ST_HOLD: begin
        if (win_expired) begin
          state_nxt = ST_FAIL;
        end else if (mode_strap_i) begin
          state_nxt = ST_SYNC;
        end
      end
      ST_SYNC: begin
        if (win_expired) begin
          state_nxt = ST_FAIL;
        end else if (arm) begin
          state_nxt = ST_MEASURE;
        end
      end
      ST_MEASURE: begin
        if (baud_done) begin
          state_nxt = ST_PROG;
        end else if (win_expired) begin
          state_nxt = ST_FAIL;
        end
      end
      ST_PROG: state_nxt = ST_PROG;
      ST_FAIL: state_nxt = ST_FAIL;
      default: state_nxt = ST_INIT;
    endcase
  end

  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      state_r <= ST_INIT;
      win_cnt_r <= 23'h000000;
      one_line_r <= 1'b1;
      baud_sel_r <= `SEL_115K;
      full_speed_r <= 1'b1;
      freq_lim_r <= 6'h00;
      strap_q_r <= 1'b1;
      rx_pin_q_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      strap_q_r <= mode_strap_i;
      rx_pin_q_r <= prog_uart_rx_i;
      // window counts from the end of all resets
      if (state_r == ST_HOLD || state_r == ST_SYNC ||
          state_r == ST_MEASURE) begin
        win_cnt_r <= win_cnt_r + 23'h000001;
      end
      // the line that falls first carries the link; one-line wins a tie
      if (arm) begin
        one_line_r <= strap_fall;
      end
      if (baud_done && state_r == ST_MEASURE) begin
        baud_sel_r <= baud_sel_det;
      end
      // sub-mode frozen at entry; supply changes later are ignored
      if (state_r == ST_INIT && por_done_i && brownout_done_i &&
          !mode_strap_i) begin
        full_speed_r <= sub_mode_full(opt_op_mode_i, vdd_ge_2v4_i);
        freq_lim_r <= freq_limit(opt_op_mode_i, vdd_ge_2v7_i);
      end
    end
  end

  prog_baud_detect u_baud (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .arm_i(arm),
    .line_i(arm ? 1'b0 : meas_line),
    .done_o(baud_done),
    .sel_o(baud_sel_det)
  );

  // ----------------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------------
  wire in_prog;
  assign in_prog = (state_r == ST_HOLD) || (state_r == ST_SYNC) ||
                   (state_r == ST_MEASURE) || (state_r == ST_PROG);
  assign normal_mode_o = (state_r == ST_NORMAL);
  assign prog_mode_o = in_prog;
  assign entry_done_o = (state_r == ST_PROG);
  assign init_timeout_o = (state_r == ST_FAIL);
  assign full_speed_o = in_prog & full_speed_r;
  assign wide_voltage_o = in_prog & ~full_speed_r;
  assign freq_limit_mhz_o = in_prog ? freq_lim_r : 6'h00;
  assign one_line_o = one_line_r;
  assign baud_sel_o = baud_sel_r;
  assign fast_osc_sel_o = in_prog;
  assign port_hold_o = in_prog;
  // no sub-mode gates any flash operation
  assign flash_ops_en_o = entry_done_o;

  // ----------------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------------
  reg rx_armed_r;
  reg rx_busy_r;
  reg [15:0] rx_cnt_r;
  reg [3:0] rx_bit_r;
  reg [7:0] rx_sh_r;
  reg tx_busy_r;
  wire [15:0] period;
  wire rx_line;
  wire rx_blocked;

  assign period = bit_cycles(baud_sel_r);
  assign rx_line = one_line_r ? mode_strap_i : prog_uart_rx_i;
  // one-line link is half duplex: our own echo is not data
  assign rx_blocked = one_line_r & tx_busy_r;

  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      rx_armed_r <= 1'b0;
      rx_busy_r <= 1'b0;
      rx_cnt_r <= 16'h0000;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 8'h00;
      rx_data_o <= 8'h00;
      rx_valid_o <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      if (state_r != ST_PROG) begin
        rx_armed_r <= 1'b0;
        rx_busy_r <= 1'b0;
        rx_cnt_r <= 16'h0000;
        rx_bit_r <= 4'h0;
      end else if (!rx_armed_r) begin
        // rest of the sync character is skipped: wait for idle line
        if (!rx_line) begin
          rx_cnt_r <= 16'h0000;
          rx_bit_r <= 4'h0;
        end else if (rx_cnt_r == period - 16'h0001) begin
          rx_cnt_r <= 16'h0000;
          if (rx_bit_r == `GUARD_BITS - 4'h1) begin
            rx_armed_r <= 1'b1;
            rx_bit_r <= 4'h0;
          end else begin
            rx_bit_r <= rx_bit_r + 4'h1;
          end
        end else begin
          rx_cnt_r <= rx_cnt_r + 16'h0001;
        end
      end else if (!rx_busy_r) begin
        if (!rx_line && !rx_blocked) begin
          rx_busy_r <= 1'b1;
          rx_cnt_r <= {1'b0, period[15:1]};
          rx_bit_r <= 4'h0;
        end
      end else if (rx_cnt_r != 16'h0000) begin
        rx_cnt_r <= rx_cnt_r - 16'h0001;
      end else begin
        rx_cnt_r <= period - 16'h0001;
        rx_bit_r <= rx_bit_r + 4'h1;
        if (rx_bit_r == 4'h0) begin
          if (rx_line) begin
            rx_busy_r <= 1'b0;
          end
        end else if (rx_bit_r == 4'h9) begin
          rx_busy_r <= 1'b0;
          if (rx_line) begin
            rx_data_o <= rx_sh_r;
            rx_valid_o <= 1'b1;
          end
        end else begin
          rx_sh_r <= {rx_line, rx_sh_r[7:1]};
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // transmitter fed by the FIFO
  // ----------------------------------------------------------------------
  wire [7:0] fifo_data;
  wire fifo_valid;
  wire fifo_pop;
  reg [9:0] tx_sh_r;
  reg [15:0] tx_cnt_r;
  reg [3:0] tx_bit_r;
  reg tx_line_r;

  // transmitter only pulls while idle, so a slow link fills the FIFO
  assign fifo_pop = (state_r == ST_PROG) & rx_armed_r & ~tx_busy_r &
                    ~rx_busy_r;

  prog_tx_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .in_data_i(tx_data_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop)
  );

  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      tx_busy_r <= 1'b0;
      tx_sh_r <= 10'h3FF;
      tx_cnt_r <= 16'h0000;
      tx_bit_r <= 4'h0;
      tx_line_r <= 1'b1;
    end else if (!tx_busy_r) begin
      tx_line_r <= 1'b1;
      if (fifo_pop && fifo_valid) begin
        tx_busy_r <= 1'b1;
        tx_sh_r <= {1'b1, fifo_data, 1'b0};
        tx_cnt_r <= 16'h0000;
        tx_bit_r <= 4'h0;
      end
    end else if (tx_cnt_r == 16'h0000) begin
      if (tx_bit_r == 4'hA) begin
        tx_busy_r <= 1'b0;
        tx_line_r <= 1'b1;
      end else begin
        tx_line_r <= tx_sh_r[0];
        tx_sh_r <= {1'b1, tx_sh_r[9:1]};
        tx_bit_r <= tx_bit_r + 4'h1;
        tx_cnt_r <= period - 16'h0001;
      end
    end else begin
      tx_cnt_r <= tx_cnt_r - 16'h0001;
    end
  end

  // one-line pin is open drain against its pull-up: drive only lows
  assign mode_strap_o = 1'b0;
  assign mode_strap_oe_o = in_prog & one_line_r & ~tx_line_r;
  assign prog_uart_tx_o = one_line_r ? 1'b1 : tx_line_r;
endmodule // flash_prog_mode_entry

// [flash_prog_entry_monitor.sv]
// assertion checker for the programming entry block
`timescale 1ns/1ps
`include "flash_prog_defines.vh"
module flash_prog_entry_monitor (
  // clock and reset
  input wire sys_clk_i,
  input wire reset_n_i,
  // strap, resets, supply, option byte
  input wire por_done_i,
  input wire brownout_done_i,
  input wire mode_strap_i,
  input wire [1:0] opt_op_mode_i,
  input wire vdd_ge_2v7_i,
  input wire vdd_ge_2v4_i,
  // status
  input wire normal_mode_o,
  input wire prog_mode_o,
  input wire entry_done_o,
  input wire init_timeout_o,
  input wire full_speed_o,
  input wire wide_voltage_o,
  input wire [5:0] freq_limit_mhz_o,
  input wire one_line_o,
  input wire [1:0] baud_sel_o,
  input wire fast_osc_sel_o,
  input wire port_hold_o,
  input wire flash_ops_en_o
);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  a_normal_strap_high: assert property (
    $rose(normal_mode_o) |-> $past(mode_strap_i) && $past(por_done_i)
      && $past(brownout_done_i))
    else $error("normal mode without strap high");
  a_prog_strap_low: assert property (
    $rose(prog_mode_o) |-> !$past(mode_strap_i) && $past(por_done_i)
      && $past(brownout_done_i))
    else $error("programming mode without strap low");
  a_mode_latched: assert property (
    normal_mode_o |=> normal_mode_o && !prog_mode_o)
    else $error("normal mode left before reset");
  a_prog_osc_hold: assert property (
    fast_osc_sel_o == prog_mode_o && port_hold_o == prog_mode_o)
    else $error("clock or pin hold not following mode");
  a_ops_after_entry: assert property (
    flash_ops_en_o == entry_done_o && (!entry_done_o || prog_mode_o))
    else $error("flash operations not tied to entry");
  a_hs_full: assert property (
    prog_mode_o && opt_op_mode_i == `OPM_HIGH_SPEED && vdd_ge_2v4_i
      |-> full_speed_o && !wide_voltage_o
      && freq_limit_mhz_o == (vdd_ge_2v7_i ? 6'h20 : 6'h10))
    else $error("high speed option not full speed");
  a_ls_lv_wide: assert property (
    prog_mode_o && opt_op_mode_i[1] |-> wide_voltage_o && !full_speed_o
      && freq_limit_mhz_o == (opt_op_mode_i == `OPM_LOW_SPEED ? 6'h08 : 6'h04))
    else $error("low speed or low voltage option not wide voltage");
  a_blank_supply: assert property (
    prog_mode_o && opt_op_mode_i == `OPM_BLANK
      |-> full_speed_o == vdd_ge_2v4_i && wide_voltage_o == !vdd_ge_2v4_i)
    else $error("blank option sub-mode wrong for supply");
  a_rate_held: assert property (
    entry_done_o |=> entry_done_o && $stable(baud_sel_o) && $stable(one_line_o))
    else $error("rate or link changed after entry");
  a_normal_quiet: assert property (
    normal_mode_o |-> !full_speed_o && !wide_voltage_o
      && freq_limit_mhz_o == 6'h00 && !entry_done_o && !init_timeout_o)
    else $error("programming outputs active in normal mode");
endmodule // flash_prog_entry_monitor

bind flash_prog_mode_entry flash_prog_entry_monitor flash_prog_entry_monitor_inst (
  .sys_clk_i, .reset_n_i, .por_done_i, .brownout_done_i, .mode_strap_i,
  .opt_op_mode_i, .vdd_ge_2v7_i, .vdd_ge_2v4_i, .normal_mode_o, .prog_mode_o,
  .entry_done_o, .init_timeout_o, .full_speed_o, .wide_voltage_o,
  .freq_limit_mhz_o, .one_line_o, .baud_sel_o, .fast_osc_sel_o, .port_hold_o,
  .flash_ops_en_o);

// [prog_host_model.sv]
// host programmer model: reset, strap and serial lines
`timescale 1ns/1ps
module prog_host_model (
  // clock
  input wire sys_clk_i,
  // pin levels seen by the host
  input wire strap_pin_i,
  input wire tx_pin_i,
  // host drive
  output reg reset_n_o,
  output reg strap_drv_o,
  output reg rx_drv_o
);
  initial begin
    reset_n_o = 1'b0;
    strap_drv_o = 1'b1;
    rx_drv_o = 1'b1;
  end
  // only the host drives reset; strap set before release
  task reset_on(input logic strap_lo);
    begin
      @(posedge sys_clk_i) #1;
      strap_drv_o = !strap_lo;
      reset_n_o = 1'b0;
    end
  endtask
  task reset_off;
    begin
      repeat (2) @(posedge sys_clk_i);
      #1 reset_n_o = 1'b1;
    end
  endtask
  task hold_release(input int hold);
    begin
      repeat (hold) @(posedge sys_clk_i);
      #1 strap_drv_o = 1'b1;
    end
  endtask
  // 8N1 frame, lsb first; released line returns high via pull-up
  task send(input logic one_line, input int per, input logic [7:0] d);
    logic [9:0] f;
    int b;
    begin
      f = {1'b1, d, 1'b0};
      for (b = 0; b < 10; b++) begin
        @(posedge sys_clk_i) #1;
        if (one_line) strap_drv_o = f[b];
        else rx_drv_o = f[b];
        repeat (per - 1) @(posedge sys_clk_i);
      end
    end
  endtask
  // sample on the falling clock edge, clear of the design's updates
  task recv(input logic one_line, input int per, output logic [7:0] d,
            output logic ok);
    int n;
    begin
      ok = 1'b0;
      d = 8'h00;
      for (n = 0; n < 40 * per && !ok; n++) begin
        @(negedge sys_clk_i);
        ok = ((one_line ? strap_pin_i : tx_pin_i) === 1'b0);
      end
      repeat (per / 2) @(negedge sys_clk_i);
      for (n = 0; n < 8; n++) begin
        repeat (per) @(negedge sys_clk_i);
        d[n] = one_line ? strap_pin_i : tx_pin_i;
      end
      repeat (per) @(negedge sys_clk_i);
    end
  endtask
endmodule // prog_host_model

// [flash_prog_mode_entry_tb.sv]
// self-checking bench for the programming entry block
`timescale 1ns/1ps
module flash_prog_mode_entry_tb;
  localparam int WIN = 2000;
  logic sys_clk_i, por_done_i, brownout_done_i, vdd_ge_2v7_i, vdd_ge_2v4_i;
  logic tx_valid_i, ol, ef, ok;
  logic [1:0] opt_op_mode_i;
  logic [7:0] tx_data_i, d, got_rx;
  logic [7:0] fr [4] = '{8'h10, 8'h20, 8'h08, 8'h04};
  wire reset_n_i, strap_drv, prog_uart_rx_i, prog_uart_tx_o, mode_strap_oe_o;
  wire normal_mode_o, prog_mode_o, entry_done_o, init_timeout_o, tx_ready_o;
  wire full_speed_o, wide_voltage_o, one_line_o, fast_osc_sel_o, port_hold_o;
  wire flash_ops_en_o, rx_valid_o, mode_strap_o;
  wire [5:0] freq_limit_mhz_o;
  wire [1:0] baud_sel_o;
  wire [7:0] rx_data_o;
  // open-drain strap pin with pull-up
  wire mode_strap_i = strap_drv & (mode_strap_oe_o ? mode_strap_o : 1'b1);
  int failures = 0, checks = 0, rx_cnt = 0, i, n, k, per, c;
  flash_prog_mode_entry #(.INIT_WINDOW_CYC(WIN)) flash_prog_mode_entry_inst (
    .sys_clk_i, .reset_n_i, .por_done_i, .brownout_done_i, .mode_strap_i,
    .mode_strap_o, .mode_strap_oe_o, .prog_uart_rx_i, .prog_uart_tx_o,
    .opt_op_mode_i, .vdd_ge_2v7_i, .vdd_ge_2v4_i, .normal_mode_o,
    .prog_mode_o, .entry_done_o, .init_timeout_o, .full_speed_o,
    .wide_voltage_o, .freq_limit_mhz_o, .one_line_o, .baud_sel_o,
    .fast_osc_sel_o, .port_hold_o, .flash_ops_en_o, .rx_data_o, .rx_valid_o,
    .tx_data_i, .tx_valid_i, .tx_ready_o);
  prog_host_model prog_host_model_inst (.sys_clk_i,
    .strap_pin_i(mode_strap_i), .tx_pin_i(prog_uart_tx_o),
    .reset_n_o(reset_n_i), .strap_drv_o(strap_drv),
    .rx_drv_o(prog_uart_rx_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    if (rx_valid_o === 1'b1) begin
      got_rx <= rx_data_o;
      rx_cnt <= rx_cnt + 1;
    end
  end
  function automatic int per_of(input int s);
    return s == 0 ? 434 : s == 1 ? 200 : s == 2 ? 100 : 50;
  endfunction
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    begin
      checks++;
      if (g !== e) begin
        failures++;
        $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // leaves valid high; caller lowers it after the last byte
  task push(input logic [7:0] v);
    begin
      tx_data_i = v;
      tx_valid_i = 1'b1;
      @(posedge sys_clk_i) #1;
    end
  endtask
  task close_out;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    repeat (90000) @(posedge sys_clk_i);
    failures++;
    close_out;
  end
  initial begin
    por_done_i = 1'b1;
    brownout_done_i = 1'b1;
    opt_op_mode_i = 2'h0;
    vdd_ge_2v7_i = 1'b1;
    vdd_ge_2v4_i = 1'b1;
    tx_data_i = 8'h00;
    tx_valid_i = 1'b0;
    prog_host_model_inst.reset_on(1'b0);
    prog_host_model_inst.reset_off;
    repeat (2) @(posedge sys_clk_i) #1;
    chk("normal", 8'h01, normal_mode_o);
    chk("osc", 8'h00, fast_osc_sel_o);
    prog_host_model_inst.send(1'b1, 5, 8'h00);
    chk("latched", 8'h01, normal_mode_o);
    chk("prog", 8'h00, prog_mode_o);
    for (i = 0; i < 4; i++) begin
      ol = i[0];
      per = per_of(i);
      prog_host_model_inst.reset_on(1'b1);
      opt_op_mode_i = i[1:0];
      vdd_ge_2v4_i = (i != 0);
      vdd_ge_2v7_i = (i == 1 || i == 2);
      prog_host_model_inst.reset_off;
      @(posedge sys_clk_i) #1;
      if (i == 2) begin
        n = 0;
        while (tx_ready_o === 1'b1 && n < 20) begin
          push(8'h10 + n[7:0]);
          n++;
        end
        tx_valid_i = 1'b0;
        chk("fill", 8'h10, n[7:0]);
      end
      prog_host_model_inst.hold_release(20);
      chk("prog", 8'h01, prog_mode_o);
      chk("hold", 8'h01, port_hold_o);
      chk("osc", 8'h01, fast_osc_sel_o);
      chk("early", 8'h00, entry_done_o);
      repeat (4) @(posedge sys_clk_i);
      fork
        prog_host_model_inst.send(ol, per, 8'hFF);
        begin
          for (k = 0; k < 16 && i == 2; k++) begin
            prog_host_model_inst.recv(ol, per, d, ok);
            chk("queued", 8'h10 + k[7:0], d);
          end
        end
      join
      chk("done", 8'h01, entry_done_o);
      chk("ops", 8'h01, flash_ops_en_o);
      chk("rate", i[7:0], baud_sel_o);
      chk("line", ol, one_line_o);
      ef = (i < 2) && vdd_ge_2v4_i;
      chk("full", ef, full_speed_o);
      chk("wide", !ef, wide_voltage_o);
      chk("freq", fr[i], freq_limit_mhz_o);
      repeat (12 * per) @(posedge sys_clk_i);
      c = rx_cnt;
      prog_host_model_inst.send(ol, per, 8'h3C ^ i[7:0]);
      repeat (per) @(posedge sys_clk_i) #1;
      chk("rx_cnt", c[7:0] + 8'h01, rx_cnt[7:0]);
      chk("rx", 8'h3C ^ i[7:0], got_rx);
      push(8'hC5 + i[7:0]);
      tx_valid_i = 1'b0;
      prog_host_model_inst.recv(ol, per, d, ok);
      chk("tx_start", 8'h01, ok);
      chk("tx", 8'hC5 + i[7:0], d);
    end
    prog_host_model_inst.reset_on(1'b1);
    prog_host_model_inst.reset_off;
    repeat (WIN + 50) @(posedge sys_clk_i);
    chk("timeout", 8'h01, init_timeout_o);
    chk("prog_off", 8'h00, prog_mode_o);
    close_out;
  end
endmodule // flash_prog_mode_entry_tb
